// >>> hw/tlo_tx_line_out.sv
// Transmit line output stage of one port: line clock, AMI pulse or NRZ pins,
// zero-substitution encoder and analog pair enable, with an AHB-Lite slave.
// Assumes hclk far above the link clock; reference clocks are pins.
//
// Notes on behaviour
// - line clock output driven only while pin enable is set.
// - line clock follows the DS3 or E3 line clock source; data follows the selected reference.
// - positive pulse output high for each positive mark in coded modes.
// - negative pulse output high for each negative mark in coded modes.
// - outputs update on reference rising edge, falling edge when inverted.
// - reference is line clock source, or tx out/in, rx line, rx out clock.
// - unipolar mode drives raw bit stream on shared positive/NRZ pin.
// - positive pulse output may be disabled while on-chip LINE_IFACE_UNIT is on and pins are disabled.
// - polarity inversion for line clock and each data output.
// - analog pair driven only with LINE_IFACE_UNIT and drive enabled, else high-Z.
// - line clock output can time frame start, serial data, enable pins.
// - line mode 000 with pins enabled disables LINE_IFACE_UNIT, digital AMI pins.
// - line mode 1XX with pins enabled gives NRZ, encoder bypassed.
// - B3ZS in DS3 modes, HDB3 in E3 modes; disable bit gives AMI.
`timescale 1ns/10ps
`include "tlo_consts.svh"

module tlo_tx_line_out
  import tlo_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_line_clk_src,
  input wire logic tx_clk_out,
  input wire logic tx_clk_in,
  input wire logic rx_line_clk_in,
  input wire logic rx_clk_out,
  input wire logic tx_serial_data_in,
  output logic tx_line_clk_out,
  output logic tx_line_clk_out_oe,
  output logic tx_pos_pulse_out,
  output logic tx_pos_pulse_out_oe,
  output logic tx_neg_pulse_out,
  output logic tx_neg_pulse_out_oe,
  output logic tx_analog_pos,
  output logic tx_analog_neg,
  output logic tx_analog_oe,
  output logic tx_ref_edge
);

  // ==================================================================
  // Register bus
  logic [31:0] ctrl_reg;
  logic [2:0] refsel_reg;
  logic ap_write;
  logic ap_read;
  logic [11:0] ap_addr;
  logic [31:0] next_hrdata;
  tlo_ctrl_t ctrl;
  logic [15:0] bit_count;
  logic [7:0] status_word;

  wire addr_phase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Bit 11 is a gap between line mode and framing mode
  assign ctrl = tlo_ctrl_t'({ctrl_reg[14:12], ctrl_reg[10:0]});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write <= 1'b0;
      ap_read <= 1'b0;
      ap_addr <= 12'h000;
    end else begin
      ap_write <= addr_phase && hwrite;
      ap_read <= addr_phase && !hwrite;
      ap_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `TLO_CTRL_RESET;
      refsel_reg <= 3'h0;
    end else if (ap_write && ap_addr == `TLO_ADDR_CTRL) begin
      ctrl_reg <= {17'h0, hwdata[14:0]};
    end else if (ap_write && ap_addr == `TLO_ADDR_REFSEL) begin
      refsel_reg <= hwdata[2:0];
    end
  end

  // Read data registered off the address phase so it stands in data phase
  always_comb begin
    next_hrdata = 32'h0;
    case (haddr)
      `TLO_ADDR_CTRL: next_hrdata = ctrl_reg;
      `TLO_ADDR_REFSEL: next_hrdata = {29'h0, refsel_reg};
      `TLO_ADDR_DATA: next_hrdata = {16'h0, bit_count};
      `TLO_ADDR_STATUS: next_hrdata = {24'h0, status_word};
      default: next_hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ==================================================================
  // Mode decode
  wire pins_en = ctrl.tx_line_pins_enable;
  wire unipolar_nrz_mode = pins_en && ctrl.line_mode_sel[2];
  wire line_iface_unit = !(pins_en && ctrl.line_mode_sel == 3'b000)
    && !unipolar_nrz_mode;
  wire e3_mode = ctrl.framing_mode_sel[2:1] == 2'b01;
  tlo_code_t code;
  assign code = unipolar_nrz_mode ? TLO_CODE_NRZ :
    ctrl.tx_zero_subst_disable ? TLO_CODE_AMI :
    e3_mode ? TLO_CODE_HDB3 : TLO_CODE_B3ZS;

  // ==================================================================
  // Reference clock sampling; all link pins pass two flops
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic ref_prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 6'h0;
      sync2 <= 6'h0;
    end else begin
      sync1 <= {tx_serial_data_in, rx_clk_out, rx_line_clk_in, tx_clk_in,
        tx_clk_out, tx_line_clk_src};
      sync2 <= sync1;
    end
  end

  logic ref_raw;
  always_comb begin
    case (tlo_ref_t'(refsel_reg))
      TLO_REF_TX_CLK_OUT: ref_raw = sync2[1];
      TLO_REF_TX_CLK_IN: ref_raw = sync2[2];
      TLO_REF_RX_LINE_CLK: ref_raw = sync2[3];
      TLO_REF_RX_CLK_OUT: ref_raw = sync2[4];
      default: ref_raw = sync2[0];
    endcase
  end
  wire ref_lvl = ref_raw ^ ctrl.ref_inv;
  wire ref_edge = ref_lvl && !ref_prev;
  wire ser_bit = sync2[5];
  assign tx_ref_edge = ref_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_lvl;
    end
  end

  // ==================================================================
  // Zero-substitution encoder, one bit per reference edge
  // Four-stage delay line lets B3ZS/HDB3 rewrite earlier zeros.
  logic [3:0] zrun;
  logic last_pol;
  logic odd_marks;
  tlo_mark_t dl [0:3];
  tlo_mark_t next_dl [0:3];
  logic next_last_pol;
  logic next_odd;
  logic [3:0] next_zrun;
  logic v_pol;

  function automatic tlo_mark_t mark_of(input logic pol);
    mark_of = tlo_mark_t'({!pol, pol});
  endfunction

  always_comb begin
    next_dl[0] = '0;
    next_dl[1] = dl[0];
    next_dl[2] = dl[1];
    next_dl[3] = dl[2];
    next_last_pol = last_pol;
    next_odd = odd_marks;
    next_zrun = ser_bit ? 4'h0 : zrun + 4'h1;
    v_pol = last_pol;
    if (ser_bit) begin
      next_last_pol = !last_pol;
      next_dl[0] = mark_of(!last_pol);
      next_odd = !odd_marks;
    end else if (code == TLO_CODE_B3ZS && zrun == 4'h2) begin
      next_zrun = 4'h0;
      if (odd_marks) begin
        next_dl[0] = mark_of(v_pol);
      end else begin
        next_dl[2] = mark_of(!last_pol);
        next_dl[0] = mark_of(!last_pol);
        next_last_pol = !last_pol;
      end
      next_odd = 1'b0;
    end else if (code == TLO_CODE_HDB3 && zrun == 4'h3) begin
      next_zrun = 4'h0;
      if (odd_marks) begin
        next_dl[0] = mark_of(v_pol);
      end else begin
        next_dl[3] = mark_of(!last_pol);
        next_dl[0] = mark_of(!last_pol);
        next_last_pol = !last_pol;
      end
      next_odd = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        dl[i] <= '0;
      end
      zrun <= 4'h0;
      last_pol <= 1'b1;
      odd_marks <= 1'b0;
      bit_count <= 16'h0;
    end else if (ref_edge) begin
      for (int i = 0; i < 4; i++) begin
        dl[i] <= next_dl[i];
      end
      zrun <= next_zrun;
      last_pol <= next_last_pol;
      odd_marks <= next_odd;
      bit_count <= bit_count + 16'h1;
    end
  end

  // ==================================================================
  // Output pins; HDB3 uses delay end, AMI/B3ZS stage 2, NRZ bypasses encoder
  logic nrz_last;
  logic pos_q;
  logic neg_q;
  wire coded_pos = code == TLO_CODE_HDB3 ? dl[3].pos : dl[2].pos;
  wire coded_neg = code == TLO_CODE_HDB3 ? dl[3].neg : dl[2].neg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nrz_last <= 1'b0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (ref_edge) begin
      nrz_last <= ser_bit;
      pos_q <= (unipolar_nrz_mode ? ser_bit : coded_pos) ^ ctrl.pos_inv;
      neg_q <= (unipolar_nrz_mode ? 1'b0 : coded_neg) ^ ctrl.neg_inv;
    end
  end

  // Line clock follows the line-rate source tx_line_clk_src, whatever reference is selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_line_clk_out <= 1'b0;
    end else begin
      tx_line_clk_out <= sync2[0] ^ ctrl.clk_inv;
    end
  end

  assign tx_line_clk_out_oe = pins_en;
  assign tx_pos_pulse_out = pos_q;
  assign tx_pos_pulse_out_oe = pins_en || (line_iface_unit && !ctrl.pos_dis);
  assign tx_neg_pulse_out = neg_q;
  assign tx_neg_pulse_out_oe = pins_en;
  // Analog pair carries coded marks; high-Z unless LINE_IFACE_UNIT and drive on
  assign tx_analog_pos = coded_pos;
  assign tx_analog_neg = coded_neg;
  assign tx_analog_oe = line_iface_unit && ctrl.ana_drv;

  assign status_word = {3'h0, nrz_last, code, unipolar_nrz_mode, line_iface_unit};

endmodule

// >>> include/tlo_consts.svh
// Offsets, field positions, reset values and timing counts for the
// transmit line output stage. Included by the design and the bench.
`ifndef TLO_CONSTS_SVH
`define TLO_CONSTS_SVH

// ====================================================================
// Register byte addresses
`define TLO_ADDR_CTRL 12'h000
`define TLO_ADDR_REFSEL 12'h004
`define TLO_ADDR_DATA 12'h008
`define TLO_ADDR_STATUS 12'h00c

// ====================================================================
// Control register fields
`define TLO_CTRL_PINS_EN 0
`define TLO_CTRL_ZSD 1
`define TLO_CTRL_POS_DIS 2
`define TLO_CTRL_ANA_DRV 3
`define TLO_CTRL_CLK_INV 4
`define TLO_CTRL_POS_INV 5
`define TLO_CTRL_NEG_INV 6
`define TLO_CTRL_REF_INV 7
`define TLO_CTRL_LM_LSB 8
`define TLO_CTRL_FM_LSB 12
`define TLO_CTRL_RESET 32'h0000_0001

// ====================================================================
// Line and hclk rates in kHz
`define TLO_DS3_RATE_KHZ 44736
`define TLO_E3_RATE_KHZ 34368
`define TLO_HCLK_KHZ 10000

`endif

// >>> include/tlo_pkg.sv
// Types shared by the transmit line output stage.
// Constants live in tlo_consts.svh.
package tlo_pkg;

  typedef enum logic [2:0] {
    TLO_REF_TX_LINE_CLK,
    TLO_REF_TX_CLK_OUT,
    TLO_REF_TX_CLK_IN,
    TLO_REF_RX_LINE_CLK,
    TLO_REF_RX_CLK_OUT
  } tlo_ref_t;

  typedef struct packed {
    logic [2:0] framing_mode_sel;
    logic [2:0] line_mode_sel;
    logic ref_inv;
    logic neg_inv;
    logic pos_inv;
    logic clk_inv;
    logic ana_drv;
    logic pos_dis;
    logic tx_zero_subst_disable;
    logic tx_line_pins_enable;
  } tlo_ctrl_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } tlo_mark_t;

  typedef enum logic [1:0] {
    TLO_CODE_AMI,
    TLO_CODE_B3ZS,
    TLO_CODE_HDB3,
    TLO_CODE_NRZ
  } tlo_code_t;

endpackage

// >>> test/tlo_tx_line_out_checker.sv
// Port-level checker for the transmit line output stage.
// Sees top-level ports only; bound into the design at the foot.
`timescale 1ns/10ps
module tlo_tx_line_out_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tx_line_clk_src,
  input wire logic tx_line_clk_out,
  input wire logic tx_line_clk_out_oe,
  input wire logic tx_pos_pulse_out_oe,
  input wire logic tx_neg_pulse_out,
  input wire logic tx_neg_pulse_out_oe,
  input wire logic tx_analog_pos,
  input wire logic tx_analog_neg,
  input wire logic tx_ref_edge
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====
  // Control writes may flip outputs at once, so judge on a quiet bus
  sequence quiet_bus;
    !hsel [*4];
  endsequence
  sequence src_moved;
    $past(tx_line_clk_src, 3) != $past(tx_line_clk_src, 4);
  endsequence
  AST_BUS_READY: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_BUS_OKAY: assert property (!hresp)
    else $error("slave gave an error response");
  AST_REF_PULSE: assert property (tx_ref_edge |=> !tx_ref_edge)
    else $error("reference pulse longer than one cycle");
  AST_NEG_UPDATE: assert property (
    quiet_bus ##0 $changed(tx_neg_pulse_out) |-> $past(tx_ref_edge))
    else $error("negative pin moved without a reference edge");
  AST_CLK_RATE: assert property (
    quiet_bus ##0 $changed(tx_line_clk_out) |-> src_moved)
    else $error("line clock output moved without the source");
  AST_ANA_ONEHOT: assert property (!(tx_analog_pos && tx_analog_neg))
    else $error("both analog marks at once");
  AST_OE_PAIR: assert property (tx_line_clk_out_oe == tx_neg_pulse_out_oe)
    else $error("clock and negative pin enables differ");
  AST_POS_OE: assert property (tx_neg_pulse_out_oe |-> tx_pos_pulse_out_oe)
    else $error("positive pin off while pins enabled");
endmodule

bind tlo_tx_line_out tlo_tx_line_out_checker chk (.hclk, .hresetn, .hsel, .hreadyout,
  .hresp, .tx_line_clk_src, .tx_line_clk_out, .tx_line_clk_out_oe, .tx_pos_pulse_out_oe,
  .tx_neg_pulse_out, .tx_neg_pulse_out_oe, .tx_analog_pos, .tx_analog_neg, .tx_ref_edge);

// >>> test/tlo_line_partner.sv
// Far-side model: free-running line clock, a half-rate alternate clock,
// and a line receiver counting marks on the pulse pins.
`timescale 1ns/10ps
module tlo_line_partner (
  output logic lclk,
  output logic slow_clk,
  input wire logic pos_pin,
  input wire logic neg_pin,
  output int pos_marks,
  output int neg_marks
);
  // Toggles just after an hclk edge, never on it
  initial begin
    lclk = 1'b0;
    slow_clk = 1'b0;
    pos_marks = 0;
    neg_marks = 0;
    #60;
    forever begin
      #400 lclk = ~lclk;
      if (!lclk) slow_clk = ~slow_clk;
    end
  end
  always @(posedge pos_pin) pos_marks++;
  always @(posedge neg_pin) neg_marks++;
endmodule

// >>> test/tlo_tx_line_out_tb_top.sv
// Self-checking bench for the transmit line output stage.
// Needs the partner model and the bound checker.
`timescale 1ns/10ps
`include "tlo_consts.svh"
module tlo_tx_line_out_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic sdata = 1'b0;
  logic [31:0] hrdata, rd;
  logic hrdy, hresp, lclk, lq, slow, ref_e, clk_o, clk_oe, pos_o, pos_oe, neg_o, neg_oe, ana_oe;
  int pm, nm, errors = 0, checked = 0, cyc = 0;
  always #50 hclk = ~hclk;
  logic lq2, lq3;
  // Source delayed by the two sync flops and the output register
  always @(posedge hclk) begin
    lq <= lclk;
    lq2 <= lq;
    lq3 <= lq2;
  end
  tlo_line_partner far (.lclk(lclk), .slow_clk(slow), .pos_pin(pos_o), .neg_pin(neg_o),
    .pos_marks(pm), .neg_marks(nm));
  tlo_tx_line_out DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .tx_line_clk_src(lclk),
    .tx_clk_out(slow), .tx_clk_in(slow), .rx_line_clk_in(slow), .rx_clk_out(slow),
    .tx_serial_data_in(sdata), .tx_line_clk_out(clk_o), .tx_line_clk_out_oe(clk_oe),
    .tx_pos_pulse_out(pos_o), .tx_pos_pulse_out_oe(pos_oe), .tx_neg_pulse_out(neg_o),
    .tx_neg_pulse_out_oe(neg_oe), .tx_analog_pos(), .tx_analog_neg(),
    .tx_analog_oe(ana_oe), .tx_ref_edge(ref_e));
  // ====
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // Single AHB-Lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // ====
  task automatic t_regs;
    bus(0, `TLO_ADDR_CTRL, 0);
    check(rd, `TLO_CTRL_RESET);
    bus(0, 12'h010, 0);
    check(rd, 0);
    bus(1, `TLO_ADDR_CTRL, 32'hf9);
    bus(0, `TLO_ADDR_CTRL, 0);
    check(rd, 32'hf9);
    $display("registers done");
  endtask
  task automatic t_modes;
    logic [31:0] cv [7] = '{32'h1, 32'h2001, 32'hb, 32'h601, 32'h108, 32'h10c, 32'h100};
    logic [5:0] ex [7] = '{6'h16, 6'h26, 6'h06, 6'h3e, 6'h13, 6'h11, 6'h12};
    for (int i = 0; i < 7; i++) begin
      bus(1, `TLO_ADDR_CTRL, cv[i]);
      bus(0, `TLO_ADDR_STATUS, 0);
      check(rd[3:1], ex[i][5:3]);
      check({clk_oe, pos_oe, ana_oe}, ex[i][2:0]);
      check(neg_oe, ex[i][2]);
    end
    $display("modes done");
  endtask
  task automatic t_nrz;
    bus(1, `TLO_ADDR_CTRL, 32'h641);
    sdata <= 1'b1;
    repeat (40) @(posedge hclk);
    check(pos_o, 1);
    check(neg_o, 1);
    sdata <= 1'b0;
    repeat (40) @(posedge hclk);
    check(pos_o, 0);
    bus(1, `TLO_ADDR_CTRL, 32'h661);
    repeat (40) @(posedge hclk);
    check(pos_o, 1);
    $display("nrz done");
  endtask
  // All ones alternate marks; all zeros give none in plain AMI
  task automatic t_ami;
    int p0, n0;
    bus(1, `TLO_ADDR_CTRL, 32'h3);
    sdata <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      repeat (64) @(posedge hclk);
      p0 = pm;
      n0 = nm;
      repeat (256) @(posedge hclk);
      check(pm - p0, k ? 0 : 16);
      check(nm - n0, k ? 0 : 16);
      sdata <= 1'b0;
    end
    $display("ami done");
  endtask
  // All zeros: B0V every 3 bits in DS3, B00V every 4 in E3; 48-bit window
  task automatic t_zsub;
    int p0, n0, bad;
    sdata <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      bus(1, `TLO_ADDR_CTRL, k ? 32'h2011 : 32'h1);
      repeat (256) @(posedge hclk);
      p0 = pm;
      n0 = nm;
      bad = 0;
      repeat (384) begin
        @(posedge hclk);
        bad += (clk_o !== (lq3 ^ k[0]));
      end
      check(pm - p0, k ? 12 : 16);
      check(nm - n0, k ? 12 : 16);
      check(bad, 0);
    end
    $display("substitution done");
  endtask
  // Each reference source, then the reference inverted
  task automatic t_ref;
    int n, hi;
    bus(1, `TLO_ADDR_CTRL, 32'h1);
    for (int s = 0; s < 6; s++) begin
      bus(1, `TLO_ADDR_REFSEL, (s == 5) ? 0 : s);
      if (s == 5) bus(1, `TLO_ADDR_CTRL, 32'h81);
      repeat (32) @(posedge hclk);
      n = 0;
      hi = 0;
      repeat (128) begin
        @(posedge hclk);
        n += (ref_e === 1'b1);
        hi += (ref_e === 1'b1 && lq === 1'b1);
      end
      check(n, (s == 0 || s == 5) ? 16 : 8);
      if (s == 0 || s == 5) check(hi, s ? 0 : 16);
    end
    $display("reference done");
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_modes();
    t_nrz();
    t_ami();
    t_zsub();
    t_ref();
    report_and_stop();
  end
endmodule
